// ### design/cold_fault_response_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cold_fault_response_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire cold_fault_pkg::cmd_s cmd,
	output logic [15:0] rd_data,
	input wire logic [15:0] temp_meas,
	input wire logic ctrl_pin,
	input wire logic op_on,
	input wire logic status_clr,
	input wire logic clear_faults,
	input wire logic other_fault,
	output logic out_en,
	output logic cold_fault,
	output logic fault_latched,
	output logic retry_attempt
);
	import cold_fault_pkg::*;

	// linear to fixed point: exponent -16..15 mapped to shift 0..31
	function automatic logic signed [41:0] lin_fixed(input logic [15:0] v);
		logic signed [41:0] m;
		logic [4:0] sh;
		m = 42'(signed'(v[10:0]));
		sh = v[15:11] ^ 5'h10;
		return m <<< sh;
	endfunction : lin_fixed

	////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] action_r, action_nxt;
	logic [15:0] thresh_r, thresh_nxt;
	logic [15:0] unit_r, unit_nxt;
	logic [15:0] rd_r, rd_nxt;

	always_comb begin
		action_nxt = action_r;
		thresh_nxt = thresh_r;
		unit_nxt = unit_r;
		rd_nxt = rd_r;
		if (cmd.wr && cmd.code == CODE_ACTION) begin
			action_nxt = cmd.data[7:0];
		end else if (cmd.wr && cmd.code == CODE_THRESHOLD) begin
			thresh_nxt = cmd.data;
		end else if (cmd.wr && cmd.code == CODE_UNIT) begin
			unit_nxt = cmd.data;
		end
		if (cmd.rd) begin
			if (cmd.code == CODE_ACTION) begin
				rd_nxt = {8'h00, action_r};
			end else if (cmd.code == CODE_THRESHOLD) begin
				rd_nxt = thresh_r;
			end else if (cmd.code == CODE_UNIT) begin
				rd_nxt = unit_r;
			end else begin
				rd_nxt = 16'h0000;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			action_r <= ACTION_RST;
			thresh_r <= THRESHOLD_RST;
			unit_r <= UNIT_RST;
			rd_r <= 16'h0000;
		end else begin
			action_r <= action_nxt;
			thresh_r <= thresh_nxt;
			unit_r <= unit_nxt;
			rd_r <= rd_nxt;
		end
	end
	assign rd_data = rd_r;

	////////////////////////////////////////////////////////////////////
	// on/off command; pin synchronised, first stage read only by second
	logic ctrl_s1_r, ctrl_s2_r, on_q_r;
	logic on_now;
	assign on_now = ctrl_s2_r & op_on;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_s1_r <= 1'b0;
			ctrl_s2_r <= 1'b0;
			on_q_r <= 1'b0;
		end else begin
			ctrl_s1_r <= ctrl_pin;
			ctrl_s2_r <= ctrl_s1_r;
			on_q_r <= on_now;
		end
	end

	////////////////////////////////////////////////////////////////////
	// response state machine
	logic [1:0] act;
	logic [2:0] retries, dly;
	logic cold, hit, expire, on_rise;
	logic [15:0] unit_eff;
	logic [TIMER_W-1:0] load;
	resp_state_e state_r, state_nxt;
	logic [TIMER_W-1:0] timer_r, timer_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic attempt_nxt, attempt_r;

	assign act = action_r[ACT_HI:ACT_LO];
	assign retries = action_r[RETRY_HI:RETRY_LO];
	assign dly = action_r[DLY_HI:DLY_LO];
	assign cold = lin_fixed(temp_meas) < lin_fixed(thresh_r);
	assign hit = cold & on_q_r;
	// zero unit length would stall the timer, so it counts as one cycle
	assign unit_eff = (unit_r == 16'h0000) ? 16'h0001 : unit_r;
	// one load value for run-on time and spacing
	assign load = TIMER_W'({8'h00, unit_eff} << dly);
	assign expire = (timer_r == TIMER_W'(1));
	assign on_rise = on_q_r & ~on_now ? 1'b0 : (on_now & ~on_q_r);

	always_comb begin
		state_nxt = state_r;
		timer_nxt = (timer_r > TIMER_W'(1)) ? timer_r - TIMER_W'(1) : timer_r;
		cnt_nxt = cnt_r;
		attempt_nxt = 1'b0;
		case (state_r)
			ST_NORMAL: begin
				cnt_nxt = 3'h0;
				if (hit) begin
					if (act == ACT_IGNORE) begin
						state_nxt = ST_NORMAL;
					end else if (act == ACT_RUN_ON) begin
						state_nxt = ST_GRACE;
						timer_nxt = load;
					end else if (act == ACT_RETRY) begin
						state_nxt = (retries == RETRY_NONE) ? ST_LATCHED
							: ST_HOLDOFF;
						timer_nxt = load;
					end else begin
						state_nxt = ST_LATCHED;
					end
				end
			end
			ST_GRACE: begin
				if (!cold) begin
					state_nxt = ST_NORMAL;
				end else if (expire) begin
					state_nxt = (retries == RETRY_NONE) ? ST_LATCHED
						: ST_HOLDOFF;
					timer_nxt = load;
				end
			end
			ST_HOLDOFF: begin
				if (expire) begin
					attempt_nxt = 1'b1;
					cnt_nxt = cnt_r + 3'h1;
					timer_nxt = load;
					if (!cold) begin
						state_nxt = ST_NORMAL;
					end else if (retries != RETRY_FOREVER &&
						cnt_r + 3'h1 >= retries) begin
						state_nxt = ST_LATCHED;
					end
				end
			end
			ST_LATCHED: begin
				if (status_clr || clear_faults) begin
					state_nxt = ST_NORMAL;
				end
			end
			default: begin
				state_nxt = ST_NORMAL;
			end
		endcase
		// off then on restarts; off or another fault also ends retrying
		if (!on_q_r || other_fault || on_rise) begin
			state_nxt = ST_NORMAL;
			cnt_nxt = 3'h0;
			attempt_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_NORMAL;
			timer_r <= '0;
			cnt_r <= 3'h0;
			attempt_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			cnt_r <= cnt_nxt;
			attempt_r <= attempt_nxt;
		end
	end

	assign out_en = on_q_r & (state_r == ST_NORMAL || state_r == ST_GRACE);
	assign cold_fault = hit;
	assign fault_latched = (state_r == ST_LATCHED);
	assign retry_attempt = attempt_r;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_hit_normal;
		state_r == ST_NORMAL && hit && on_now && !other_fault;
	endsequence

	property p_ignore;
		@(posedge sys_clk) disable iff (!rst_n)
		s_hit_normal ##0 act == ACT_IGNORE |=> state_r == ST_NORMAL && out_en;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ignore left normal");

	property p_run_on;
		@(posedge sys_clk) disable iff (!rst_n)
		s_hit_normal ##0 act == ACT_RUN_ON |=> state_r == ST_GRACE && out_en
			&& timer_r == $past(load);
	endproperty
	a_run_on: assert property (p_run_on)
		else $error("run-on not started");

	property p_disable;
		@(posedge sys_clk) disable iff (!rst_n)
		s_hit_normal ##0 act == ACT_RETRY |=> !out_en;
	endproperty
	a_disable: assert property (p_disable)
		else $error("output not disabled");

	property p_latch;
		@(posedge sys_clk) disable iff (!rst_n)
		s_hit_normal ##0 act == ACT_LATCH |=> fault_latched ##1
			(fault_latched || $past(status_clr || clear_faults || !on_now
			|| other_fault));
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch not held");

	property p_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		fault_latched && (status_clr || clear_faults) |=> !fault_latched;
	endproperty
	a_clear: assert property (p_clear)
		else $error("latch not cleared");

	property p_off;
		@(posedge sys_clk) disable iff (!rst_n)
		!on_q_r |=> state_r == ST_NORMAL && !retry_attempt;
	endproperty
	a_off: assert property (p_off)
		else $error("off did not reset");

	property p_no_retry;
		@(posedge sys_clk) disable iff (!rst_n)
		s_hit_normal ##0 act == ACT_RETRY && retries == RETRY_NONE
			|=> fault_latched;
	endproperty
	a_no_retry: assert property (p_no_retry)
		else $error("retried at 000");

	property p_exhaust;
		@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_HOLDOFF && expire && hit && on_now && !other_fault
			&& retries != RETRY_FOREVER && cnt_r + 3'h1 >= retries
			|=> fault_latched && !out_en && retry_attempt;
	endproperty
	a_exhaust: assert property (p_exhaust)
		else $error("attempts not ended");

	property p_spacing;
		@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_HOLDOFF && expire && on_q_r && on_now && !other_fault
			|=> retry_attempt && timer_r == $past(load);
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("spacing wrong");

	property p_forever;
		@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_HOLDOFF && expire && hit && on_now && !other_fault
			&& retries == RETRY_FOREVER |=> state_r == ST_HOLDOFF;
	endproperty
	a_forever: assert property (p_forever)
		else $error("forever retry stopped");
endmodule : cold_fault_response_ctrl
`default_nettype wire

// ### design/cold_fault_pkg.sv
package cold_fault_pkg;
	// command codes of the registers
	localparam logic [7:0] CODE_THRESHOLD = 8'h53;
	localparam logic [7:0] CODE_ACTION = 8'h54;
	localparam logic [7:0] CODE_UNIT = 8'hD2;
	// field positions of the action register
	localparam int ACT_HI = 7;
	localparam int ACT_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI = 2;
	localparam int DLY_LO = 0;
	// action codes
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_RUN_ON = 2'h1;
	localparam logic [1:0] ACT_RETRY = 2'h2;
	localparam logic [1:0] ACT_LATCH = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// reset values
	localparam logic [7:0] ACTION_RST = 8'h00;
	localparam logic [15:0] THRESHOLD_RST = 16'h0000;
	// one delay unit, in ns, and its length in sys_clk cycles
	localparam int CLK_PERIOD_NS = 20;
	localparam int DELAY_UNIT_NS = 1000;
	localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [15:0] UNIT_RST = 16'(DELAY_UNIT_CYC);
	localparam int TIMER_W = 24;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0001,
		ST_GRACE = 4'b0010,
		ST_HOLDOFF = 4'b0100,
		ST_LATCHED = 4'b1000
	} resp_state_e;

	typedef struct packed {
		logic [7:0] code;
		logic [15:0] data;
		logic wr;
		logic rd;
	} cmd_s;
endpackage : cold_fault_pkg

// ### bench/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
	input wire logic sys_clk,
	input wire logic [15:0] rd_data,
	output var cold_fault_pkg::cmd_s cmd,
	output logic ctrl_pin,
	output logic op_on,
	output logic status_clr,
	output logic clear_faults
);
	import cold_fault_pkg::*;
	initial begin
		cmd = '0;
		ctrl_pin = 1'b1;
		op_on = 1'b1;
		status_clr = 1'b0;
		clear_faults = 1'b0;
	end
	////////////////////////////////////////////////////////////////////
	// idle data is inverted so a stale value is never mistaken for new
	task automatic xfer(input logic [7:0] c, input logic [15:0] d,
		input logic w);
		@(negedge sys_clk);
		cmd <= '{code: c, data: d, wr: w, rd: !w};
		@(negedge sys_clk);
		cmd <= '{code: 8'h00, data: ~d, wr: 1'b0, rd: 1'b0};
	endtask : xfer
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		xfer(c, 16'h0000, 1'b0);
		d = rd_data;
	endtask : rd
	task automatic pulse(input int k);
		@(negedge sys_clk);
		if (k == 0) status_clr <= 1'b1;
		else clear_faults <= 1'b1;
		@(negedge sys_clk);
		status_clr <= 1'b0;
		clear_faults <= 1'b0;
	endtask : pulse
	// off long enough for the pin synchroniser to see it
	task automatic off_on(input bit pin);
		@(negedge sys_clk);
		if (pin) ctrl_pin <= 1'b0;
		else op_on <= 1'b0;
		repeat (6) @(negedge sys_clk);
		ctrl_pin <= 1'b1;
		op_on <= 1'b1;
		repeat (6) @(negedge sys_clk);
	endtask : off_on
endmodule : pmbus_host_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cold_fault_pkg::*;
	localparam logic [15:0] COLD = 16'hFFFF;
	localparam logic [15:0] WARM = 16'h0019;
	logic sys_clk, rst_n, ctrl_pin, op_on, status_clr, clear_faults;
	logic other_fault, out_en, cold_fault, fault_latched, retry_attempt;
	logic [15:0] rd_data, temp_meas;
	cmd_s cmd;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	pmbus_host_model host (.sys_clk(sys_clk), .rd_data(rd_data),
		.cmd(cmd), .ctrl_pin(ctrl_pin), .op_on(op_on),
		.status_clr(status_clr), .clear_faults(clear_faults));
	cold_fault_response_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.cmd(cmd), .rd_data(rd_data), .temp_meas(temp_meas),
		.ctrl_pin(ctrl_pin), .op_on(op_on), .status_clr(status_clr),
		.clear_faults(clear_faults), .other_fault(other_fault),
		.out_en(out_en), .cold_fault(cold_fault),
		.fault_latched(fault_latched), .retry_attempt(retry_attempt));
	always #10 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	// ceiling well above the roughly 1800 cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic act(input logic [1:0] a, input logic [2:0] r,
		input logic [2:0] d);
		host.xfer(CODE_ACTION, {8'h00, a, r, d}, 1'b1);
	endtask : act
	// counts attempt pulses and flags any uneven spacing
	task automatic watch(input int cyc, input int gap, output int cnt,
		output bit bad);
		int last;
		last = -1;
		cnt = 0;
		bad = 0;
		for (int i = 0; i < cyc; i++) begin
			@(negedge sys_clk);
			if (retry_attempt === 1'b1) begin
				if (last >= 0 && i - last != gap) bad = 1;
				last = i;
				cnt++;
			end
		end
	endtask : watch
	////////////////////////////////////////////////////////////////////
	task automatic test_regs();
		logic [15:0] v;
		host.rd(CODE_ACTION, v);
		chk(v, {8'h00, ACTION_RST});
		host.rd(CODE_THRESHOLD, v);
		chk(v, THRESHOLD_RST);
		host.rd(CODE_UNIT, v);
		chk(v, UNIT_RST);
		host.xfer(CODE_UNIT, 16'h0001, 1'b1);
		host.xfer(8'h55, 16'h1234, 1'b1);
		host.xfer(CODE_THRESHOLD, 16'h0014, 1'b1);
		host.xfer(CODE_ACTION, 16'h00A5, 1'b1);
		host.rd(CODE_UNIT, v);
		chk(v, 16'h0001);
		host.rd(8'h55, v);
		chk(v, 16'h0000);
		host.rd(CODE_THRESHOLD, v);
		chk(v, 16'h0014);
		host.rd(CODE_ACTION, v);
		chk(v, 16'h00A5);
		$display("test regs done");
	endtask : test_regs
	task automatic test_ignore();
		int cnt;
		bit bad;
		act(ACT_IGNORE, 3'd1, 3'd0);
		temp_meas = COLD;
		watch(30, 1, cnt, bad);
		chk(16'(cnt), 16'h0000);
		chk(16'(out_en), 16'h0001);
		chk(16'(cold_fault), 16'h0001);
		temp_meas = WARM;
		repeat (3) @(negedge sys_clk);
		chk(16'(cold_fault), 16'h0000);
		$display("test ignore done");
	endtask : test_ignore
	task automatic test_latch();
		for (int k = 0; k < 4; k++) begin
			act(ACT_LATCH, RETRY_NONE, 3'd0);
			temp_meas = COLD;
			repeat (4) @(negedge sys_clk);
			chk(16'(out_en), 16'h0000);
			chk(16'(fault_latched), 16'h0001);
			temp_meas = WARM;
			repeat (10) @(negedge sys_clk);
			chk(16'(out_en), 16'h0000);
			chk(16'(fault_latched), 16'h0001);
			if (k < 2) host.pulse(k);
			else host.off_on(k == 3);
			repeat (4) @(negedge sys_clk);
			chk(16'(out_en), 16'h0001);
			chk(16'(fault_latched), 16'h0000);
		end
		$display("test latch done");
	endtask : test_latch
	task automatic test_run_on();
		int t;
		act(ACT_RUN_ON, 3'd1, 3'd3);
		temp_meas = COLD;
		t = 0;
		while (out_en === 1'b1 && t < 50) begin
			@(negedge sys_clk);
			t++;
		end
		// eight units of run-on plus the edge that sees the fault
		chk(16'(t), 16'((1 << 3) + 1));
		temp_meas = WARM;
		repeat (20) @(negedge sys_clk);
		chk(16'(out_en), 16'h0001);
		chk(16'(fault_latched), 16'h0000);
		$display("test run_on done");
	endtask : test_run_on
	// delay field i, attempts i, except the top delay with one attempt
	task automatic test_retry();
		int cnt, n;
		bit bad;
		for (int i = 0; i < 8; i++) begin
			n = (i == 7) ? 1 : i;
			act(ACT_RETRY, 3'(n), 3'(i));
			temp_meas = COLD;
			watch((n + 2) * (1 << i) + 10, 1 << i, cnt, bad);
			chk(16'(cnt), 16'(n));
			chk(16'(bad), 16'h0000);
			chk(16'(out_en), 16'h0000);
			chk(16'(fault_latched), 16'h0001);
			temp_meas = WARM;
			host.off_on(1'b0);
			chk(16'(out_en), 16'h0001);
		end
		$display("test retry done");
	endtask : test_retry
	task automatic test_forever();
		int cnt;
		bit bad;
		act(ACT_RETRY, RETRY_FOREVER, 3'd1);
		temp_meas = COLD;
		watch(60, 2, cnt, bad);
		chk(16'(cnt > 20), 16'h0001);
		chk(16'(bad), 16'h0000);
		chk(16'(fault_latched), 16'h0000);
		other_fault = 1'b1;
		repeat (3) @(negedge sys_clk);
		watch(30, 2, cnt, bad);
		chk(16'(cnt), 16'h0000);
		other_fault = 1'b0;
		temp_meas = WARM;
		host.off_on(1'b0);
		chk(16'(out_en), 16'h0001);
		$display("test forever done");
	endtask : test_forever
	// mid-run reset drops a latched fault and restores the registers
	task automatic test_reset();
		logic [15:0] v;
		act(ACT_LATCH, RETRY_NONE, 3'd0);
		temp_meas = COLD;
		repeat (4) @(negedge sys_clk);
		chk(16'(fault_latched), 16'h0001);
		rst_n = 1'b0;
		@(negedge sys_clk);
		chk(16'(fault_latched), 16'h0000);
		chk(16'(out_en), 16'h0000);
		chk(rd_data, 16'h0000);
		rst_n = 1'b1;
		temp_meas = WARM;
		// pin synchroniser and on register need three edges
		repeat (4) @(negedge sys_clk);
		chk(16'(out_en), 16'h0001);
		chk(16'(fault_latched), 16'h0000);
		host.rd(CODE_ACTION, v);
		chk(v, {8'h00, ACTION_RST});
		$display("test reset done");
	endtask : test_reset
	////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		temp_meas = WARM;
		other_fault = 1'b0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		test_regs();
		test_ignore();
		test_latch();
		test_run_on();
		test_retry();
		test_forever();
		test_reset();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
